// [include/pcmc_pkg.sv]
`default_nettype none
package pcmc_pkg;
  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [5:0] PCMC_IDX_FORMAT = 6'h04;
  localparam logic [5:0] PCMC_IDX_COMP = 6'h05;
  localparam logic [5:0] PCMC_IDX_STATUS = 6'h06;
  localparam logic [5:0] PCMC_COMP_RESET = 6'h00;
  localparam logic [1:0] PCMC_WORD_LENGTH_FIELD_RESET = 2'h0;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int PCMC_ADC_LAW_BIT = 1;
  localparam int PCMC_ADC_EN_BIT = 2;
  localparam int PCMC_DAC_LAW_BIT = 3;
  localparam int PCMC_DAC_EN_BIT = 4;
  localparam int PCMC_EIGHT_BIT = 5;
  localparam int PCMC_WORD_LENGTH_FIELD_LSB = 5;
  localparam int PCMC_WORD_LENGTH_FIELD_MSB = 6;
  // ------------------------------------------------------------
  // Word lengths in bits
  // ------------------------------------------------------------
  localparam logic [5:0] PCMC_BITS_8 = 6'h08;
  localparam logic [5:0] PCMC_BITS_16 = 6'h10;
  localparam logic [5:0] PCMC_BITS_20 = 6'h14;
  localparam logic [5:0] PCMC_BITS_24 = 6'h18;
  localparam logic [5:0] PCMC_BITS_32 = 6'h20;
  // ------------------------------------------------------------
  // Companding constants
  // ------------------------------------------------------------
  localparam logic [13:0] PCMC_MU_CLIP = 14'h1FDE;
  localparam logic [13:0] PCMC_MU_BIAS = 14'h0021;
  localparam logic [15:0] PCMC_MU_DBIAS = 16'h0084;
  localparam logic [7:0] PCMC_A_POS_MASK = 8'hD5;
  localparam logic [7:0] PCMC_A_NEG_MASK = 8'h55;
  localparam logic [15:0] PCMC_A_SEG0_ADD = 16'h0008;
  localparam logic [15:0] PCMC_A_SEGN_ADD = 16'h0108;

  function automatic logic [7:0] pcmc_mu_enc(input logic [15:0] s);
    logic sign;
    logic [13:0] mag;
    logic [2:0] seg;
    logic [3:0] man;
    sign = s[15];
    mag = sign ? 14'(-($signed(s) >>> 2)) : 14'($signed(s) >>> 2);
    if (mag > PCMC_MU_CLIP) begin
      mag = PCMC_MU_CLIP;
    end
    mag = mag + PCMC_MU_BIAS;
    seg = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (mag[i + 5]) begin
        seg = 3'(i);
      end
    end
    man = 4'(mag >> (4'(seg) + 4'h1));
    return ~{sign, seg, man};
  endfunction : pcmc_mu_enc

  function automatic logic [7:0] pcmc_a_enc(input logic [15:0] s);
    logic sign;
    logic [11:0] mag;
    logic [2:0] seg;
    logic [3:0] man;
    sign = s[15];
    mag = sign ? 12'(~($signed(s) >>> 3)) : 12'($signed(s) >>> 3);
    seg = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (mag[i + 5]) begin
        seg = 3'(i + 1);
      end
    end
    man = (seg == 3'h0) ? 4'(mag >> 1) : 4'(mag >> seg);
    return {1'b0, seg, man} ^ (sign ? PCMC_A_NEG_MASK : PCMC_A_POS_MASK);
  endfunction : pcmc_a_enc

  function automatic logic [15:0] pcmc_mu_dec(input logic [7:0] c);
    logic [7:0] v;
    logic [15:0] t;
    v = ~c;
    t = ((16'(v[3:0]) << 3) + PCMC_MU_DBIAS) << v[6:4];
    return v[7] ? PCMC_MU_DBIAS - t : t - PCMC_MU_DBIAS;
  endfunction : pcmc_mu_dec

  function automatic logic [15:0] pcmc_a_dec(input logic [7:0] c);
    logic [7:0] v;
    logic [15:0] t;
    v = c ^ PCMC_A_NEG_MASK;
    t = 16'(v[3:0]) << 4;
    if (v[6:4] == 3'h0) begin
      t = t + PCMC_A_SEG0_ADD;
    end else begin
      t = (t + PCMC_A_SEGN_ADD) << (v[6:4] - 3'h1);
    end
    return v[7] ? t : 16'(-t);
  endfunction : pcmc_a_dec
endpackage : pcmc_pkg
`default_nettype wire

// [rtl/pcmc_top.sv]
// Function
// - Offer A-law and mu-law on both the ADC and the DAC direction.
// - Compress 14-bit mu-law or 13-bit A-law linear samples to 8 bits.
// - Each companded word is 8 bits: sign, 3-bit exponent, 4-bit mantissa.
// - Mu-law follows the standard logarithmic curve with mu of 255.
// - A-law follows the standard curve with A of 87.6.
// - Control bits: 4 DAC enable, 3 DAC law, 2 ADC enable, 1 ADC law.
// - Bit 5 set forces 8-bit words and ignores the word-length field.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module pcmc_top
  import pcmc_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [15:0] adc_sample_in,
  input wire logic adc_valid_in,
  output logic adc_ready_out,
  output logic [15:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [15:0] rx_data_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output logic [15:0] dac_sample_out,
  output logic dac_valid_out,
  input wire logic dac_ready_in,
  output logic [5:0] xfer_bits_out
);
  import pcmc_pkg::*;

  logic [5:0] comp_q;
  logic [1:0] word_length_field_q;
  logic [15:0] skid_q;
  logic skid_vld_q;
  logic bus_req;
  logic [5:0] idx;
  logic adc_fire;
  logic rx_fire;
  logic [7:0] enc_word;
  logic [15:0] tx_word;
  logic [15:0] dec_word;
  logic [31:0] rd_d;
  logic dac_vld_d;

  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign idx = 6'(wb_adr_in >> 2);
  assign adc_fire = adc_valid_in && adc_ready_out;
  assign rx_fire = rx_valid_in && rx_ready_out;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  always_comb begin
    rd_d = 32'h0000_0000;
    if (idx == PCMC_IDX_FORMAT) begin
      rd_d[PCMC_WORD_LENGTH_FIELD_MSB:PCMC_WORD_LENGTH_FIELD_LSB] = word_length_field_q;
    end else if (idx == PCMC_IDX_COMP) begin
      rd_d[5:0] = comp_q;
    end else if (idx == PCMC_IDX_STATUS) begin
      rd_d[3:0] = {dac_valid_out, skid_vld_q, tx_valid_out, adc_ready_out};
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_req ? rd_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      comp_q <= PCMC_COMP_RESET;
      word_length_field_q <= PCMC_WORD_LENGTH_FIELD_RESET;
    end else if (bus_req && wb_we_in && wb_sel_in[0]) begin
      if (idx == PCMC_IDX_COMP) begin
        comp_q <= {wb_dat_in[5:1], 1'b0};
      end else if (idx == PCMC_IDX_FORMAT) begin
        word_length_field_q <= wb_dat_in[PCMC_WORD_LENGTH_FIELD_MSB:PCMC_WORD_LENGTH_FIELD_LSB];
      end
    end
  end

  // ------------------------------------------------------------
  // Word length seen by the serial interface
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      xfer_bits_out <= PCMC_BITS_16;
    end else if (comp_q[PCMC_EIGHT_BIT]) begin
      xfer_bits_out <= PCMC_BITS_8;
    end else begin
      case (word_length_field_q)
        2'h0: xfer_bits_out <= PCMC_BITS_16;
        2'h1: xfer_bits_out <= PCMC_BITS_20;
        2'h2: xfer_bits_out <= PCMC_BITS_24;
        default: xfer_bits_out <= PCMC_BITS_32;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Transmit path: compress, then two-entry buffer
  // ------------------------------------------------------------
  // Law chosen per sample as it is accepted
  assign enc_word = comp_q[PCMC_ADC_LAW_BIT] ? pcmc_a_enc(adc_sample_in)
                                            : pcmc_mu_enc(adc_sample_in);
  // Inverted forms are produced by the encoders
  assign tx_word = comp_q[PCMC_ADC_EN_BIT] ? {8'h00, enc_word}
                                           : adc_sample_in;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_data_out <= 16'h0000;
      tx_valid_out <= 1'b0;
      skid_q <= 16'h0000;
      skid_vld_q <= 1'b0;
    end else if (!tx_valid_out || tx_ready_in) begin
      if (skid_vld_q) begin
        tx_data_out <= skid_q;
        skid_vld_q <= 1'b0;
      end else if (adc_fire) begin
        tx_data_out <= tx_word;
      end
      tx_valid_out <= skid_vld_q || adc_fire;
    end else if (adc_fire) begin
      skid_q <= tx_word;
      skid_vld_q <= 1'b1;
    end
  end

  // Ready falls once the skid entry would be taken
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      adc_ready_out <= 1'b0;
    end else if (!tx_valid_out || tx_ready_in) begin
      adc_ready_out <= 1'b1;
    end else begin
      adc_ready_out <= !(skid_vld_q || adc_fire);
    end
  end

  // ------------------------------------------------------------
  // Receive path: un-invert and expand into the DAC path
  // ------------------------------------------------------------
  always_comb begin
    dec_word = rx_data_in;
    if (comp_q[PCMC_DAC_EN_BIT]) begin
      dec_word = comp_q[PCMC_DAC_LAW_BIT] ? pcmc_a_dec(rx_data_in[7:0])
                                          : pcmc_mu_dec(rx_data_in[7:0]);
    end
  end

  assign dac_vld_d = rx_fire || (dac_valid_out && !dac_ready_in);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dac_sample_out <= 16'h0000;
      dac_valid_out <= 1'b0;
      rx_ready_out <= 1'b0;
    end else begin
      if (rx_fire) begin
        dac_sample_out <= dec_word;
      end
      dac_valid_out <= dac_vld_d;
      rx_ready_out <= !dac_vld_d;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  ctrl_write_a: assert property (
    (bus_req && wb_we_in && wb_sel_in[0] && idx == PCMC_IDX_COMP)
    |=> comp_q == {$past(wb_dat_in[5:1]), 1'b0})
    else $error("control write not stored");
  eight_bit_a: assert property (
    $past(comp_q[PCMC_EIGHT_BIT]) |-> xfer_bits_out == PCMC_BITS_8)
    else $error("8-bit mode not forced");
  mu_zero_a: assert property (
    (!comp_q[PCMC_ADC_LAW_BIT] && adc_sample_in == 16'h0000)
    |-> enc_word == 8'hFF)
    else $error("mu-law zero code wrong");
  alaw_zero_a: assert property (
    (comp_q[PCMC_ADC_LAW_BIT] && adc_sample_in == 16'h0000)
    |-> enc_word == PCMC_A_POS_MASK)
    else $error("A-law zero code wrong");
  alaw_max_a: assert property (
    (comp_q[PCMC_ADC_LAW_BIT] && adc_sample_in == 16'h7FFF)
    |-> enc_word == 8'hAA)
    else $error("A-law full scale code wrong");
  tx_width_a: assert property (
    (adc_fire && comp_q[PCMC_ADC_EN_BIT] && !tx_valid_out)
    |=> tx_valid_out && tx_data_out[15:8] == 8'h00)
    else $error("companded word wider than 8 bits");
  mu_expand_a: assert property (
    (rx_fire && comp_q[PCMC_DAC_EN_BIT] && !comp_q[PCMC_DAC_LAW_BIT]
     && rx_data_in[7:0] == 8'hFF) |=> dac_sample_out == 16'h0000)
    else $error("mu-law expansion of idle code wrong");
  dac_bypass_a: assert property (
    (rx_fire && !comp_q[PCMC_DAC_EN_BIT])
    |=> dac_valid_out && dac_sample_out == $past(rx_data_in))
    else $error("linear word altered with expansion off");
  tx_hold_a: assert property (
    (tx_valid_out && !tx_ready_in) |=> tx_valid_out && $stable(tx_data_out))
    else $error("transmit word changed while stalled");

  full_cov: cover property (skid_vld_q && tx_valid_out);
  alaw_tx_cov: cover property (
    adc_fire && comp_q[PCMC_ADC_EN_BIT] && comp_q[PCMC_ADC_LAW_BIT]);
  mu_rx_cov: cover property (
    rx_fire && comp_q[PCMC_DAC_EN_BIT] && !comp_q[PCMC_DAC_LAW_BIT]);
  stall_cov: cover property (dac_valid_out && !dac_ready_in ##1 rx_valid_in);
endmodule : pcmc_top
`default_nettype wire

// [sim/pcmc_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pcmc_host_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic rx_ready_in,
  output logic tx_ready_out,
  output logic [15:0] rx_data_out,
  output logic rx_valid_out
);
  initial begin
    tx_ready_out = 1'b0;
    rx_data_out = 16'hFFFF;
    rx_valid_out = 1'b0;
  end
  // Serialiser sink, prompt or slow as told
  always @(posedge clk_in) begin
    tx_ready_out <= !stall_in;
  end
  // Receiver source; a released line shows the inverse of the last word
  task automatic send(input logic [15:0] w);
    rx_data_out <= w;
    rx_valid_out <= 1'b1;
    do @(posedge clk_in); while (rx_ready_in !== 1'b1);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~w;
    @(posedge clk_in);
  endtask : send
endmodule : pcmc_host_model
`default_nettype wire

// [sim/test_pcmc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module test_pcmc_top;
  import pcmc_pkg::*;
  logic clk_in, arst_n_in, cyc, stb, we, adc_v, stall, dac_rdy, rnd_on;
  logic wb_ack_out, adc_rdy, tx_v, tx_rdy, rx_v, rx_rdy, dac_v;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, wb_dat_out, seed, r, r2;
  logic [15:0] adc_s, tx_data, rx_data, dac_s;
  logic [5:0] xbits;
  logic [31:0] rd_q[$], tx_q[$], dac_q[$];
  int num_errors, compares;
  logic [15:0] smp[4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
  logic [7:0] enc[2][4] = '{'{8'hFF, 8'h80, 8'h00, 8'h7E},
    '{8'hD5, 8'hAA, 8'h2A, 8'h55}};
  logic [15:0] dec[2][4] = '{'{16'h0000, 16'h7D7C, 16'h8284, 16'hFFF8},
    '{16'h0008, 16'h7E00, 16'h8200, 16'hFFF8}};
  pcmc_top pcmc_top_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .adc_sample_in(adc_s), .adc_valid_in(adc_v),
    .adc_ready_out(adc_rdy), .tx_data_out(tx_data), .tx_valid_out(tx_v),
    .tx_ready_in(tx_rdy), .rx_data_in(rx_data), .rx_valid_in(rx_v),
    .rx_ready_out(rx_rdy), .dac_sample_out(dac_s), .dac_valid_out(dac_v),
    .dac_ready_in(dac_rdy), .xfer_bits_out(xbits));
  pcmc_host_model pcmc_host_model_inst (.clk_in(clk_in), .stall_in(stall),
    .rx_ready_in(rx_rdy), .tx_ready_out(tx_rdy), .rx_data_out(rx_data),
    .rx_valid_out(rx_v));
  function automatic logic [31:0] nx();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nx
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    if (!w) rd_q.push_back(e);
    do @(posedge clk_in); while (wb_ack_out !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  // Leaves valid high so samples can follow back to back
  task automatic adc(input logic [15:0] s, input logic [31:0] e);
    adc_s <= s;
    adc_v <= 1'b1;
    tx_q.push_back(e);
    do @(posedge clk_in); while (adc_rdy !== 1'b1);
  endtask : adc
  task automatic rx(input logic [15:0] w, input logic [15:0] e);
    dac_q.push_back({16'h0000, e});
    pcmc_host_model_inst.send(w);
  endtask : rx
  // --------------------------------------------------
  // Random stalls and output watcher
  // --------------------------------------------------
  always @(posedge clk_in) begin
    if (rnd_on) begin
      r2 = nx();
      stall <= r2[0];
      dac_rdy <= r2[1] | r2[2];
    end
    if (tx_v === 1'b1 && tx_rdy === 1'b1)
      chk(tx_q.size() ? tx_q.pop_front() : 32'hFFFF_FFFF, {16'h0, tx_data});
    if (dac_v === 1'b1 && dac_rdy === 1'b1)
      chk(dac_q.size() ? dac_q.pop_front() : 32'hFFFF_FFFF, {16'h0, dac_s});
    if (wb_ack_out === 1'b1 && we === 1'b0)
      chk(rd_q.size() ? rd_q.pop_front() : 32'hFFFF_FFFF, wb_dat_out);
  end
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
  initial begin
    arst_n_in = 0; cyc = 0; stb = 0; we = 0; adc_v = 0; stall = 0;
    dac_rdy = 1; rnd_on = 0; adr = 0; sel = 4'hF; wdat = 0; adc_s = 0;
    seed = 32'h0000_000C; num_errors = 0; compares = 0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    chk(32'(PCMC_BITS_16), 32'(xbits));
    bus(0, 8'h14, 0, 32'h0000_0000);
    bus(0, 8'h40, 0, 32'h0000_0000);
    bus(1, 8'h10, 32'h0000_0060, 0);
    bus(0, 8'h10, 0, 32'h0000_0060);
    chk(32'(PCMC_BITS_32), 32'(xbits));
    bus(1, 8'h14, 32'h0000_0020, 0);
    chk(32'(PCMC_BITS_8), 32'(xbits));
    bus(1, 8'h14, 32'h0000_003F, 0);
    sel <= 4'h0;
    bus(1, 8'h14, 32'h0000_0000, 0);
    sel <= 4'hF;
    bus(0, 8'h14, 0, 32'h0000_003E);
    bus(1, 8'h14, 32'h0000_0000, 0);
    chk(32'(PCMC_BITS_32), 32'(xbits));
    rnd_on <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      r = nx();
      adc(r[15:0], {16'h0000, r[15:0]});
    end
    adc_v <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = nx();
      rx(r[15:0], r[15:0]);
    end
    rnd_on <= 1'b0;
    stall <= 1'b0;
    dac_rdy <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      bus(1, 8'h14, {26'h0, 2'b11, m[1], 1'b1, m[0], 1'b0}, 0);
      for (int k = 0; k < 4; k++)
        adc(smp[k], {24'h0, enc[m[0]][k]});
      adc_v <= 1'b0;
      for (int k = 0; k < 4; k++)
        rx({8'h00, enc[m[1]][k]}, dec[m[1]][k]);
    end
    bus(1, 8'h14, 32'h0000_0024, 0);
    rx(16'h1234, 16'h1234);
    adc(16'h8000, 32'h0000_0000);
    adc_v <= 1'b0;
    bus(1, 8'h14, 32'h0000_0000, 0);
    stall <= 1'b1;
    adc(16'h1111, 32'h0000_1111);
    adc(16'h2222, 32'h0000_2222);
    adc_v <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(32'h0, {31'h0, adc_rdy});
    bus(0, 8'h18, 0, 32'h0000_0006);
    stall <= 1'b0;
    adc(16'h3333, 32'h0000_3333);
    adc_v <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk(32'h0, tx_q.size() + dac_q.size() + rd_q.size());
    test_done();
  end
endmodule : test_pcmc_top
`default_nettype wire
